// ==== hdl/rcrb_rail_control_bank.v ====
// Overview of operation
// - power-ok asserts a programmed delay after all rails reach regulation.
// - delay code resets to 7 (100 ms); codes 0..6 give 2.5..75 ms.
// - writing one to force-shutdown triggers emergency shutdown; zero does nothing.
// - force-shutdown bit 0 self-clears; other bits of that register read zero.
// - converter four code is 7-bit RW, resets to the 1.80 V pattern.
// - code zero is a valid 0 V setting; power-good stays high then.
// - converter five code is 7-bit RW, resets to the 1.24 V pattern.
// - converter six code resets per factory variant: 1.1, 1.20 or 1.35 V.
// - linear regulator two uses sleep code while sleep-state is low.
// - linear regulator three likewise; nibbles reset to 1011 or 0000 per variant.
// - bits 5..3 pick auto (0) or forced PWM (1); bit 5 reset per variant.
// - zero force-off bit turns converter off, overriding pins and override.
// - on-override for converters one..three forces on unless force-off is zero.
// - on-override bits 3..5 force converters four..six on.
// - bit 7 zero gates linear regulator two by the enable pin; one forces on.
// - bit 6 zero gates switch A by either pin; one forces it on.
`include "rcrb_defs.vh"
module rcrb_rail_control_bank #(
  parameter [1:0] VARIANT = 2'h0,
  parameter integer US_SCALE = 1
) (
  input wire clk,
  input wire nrst,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  input wire sleepStateN,
  input wire linearSwitchEnablePin,
  input wire switchAEnablePin,
  input wire [5:0] seqConvEnable,
  input wire allRailsInRegulation,
  input wire [5:0] railPowerGoodRaw,
  output reg platformPowerOkOut,
  output reg emergencyShutdown,
  output reg [5:0] convOn,
  output reg [2:0] convPwmSelect,
  output reg linregTwoOn,
  output reg switchAOn,
  output reg [3:0] linregTwoCode,
  output reg [3:0] linregThreeCode,
  output reg [6:0] convFourCode,
  output reg [6:0] convFiveCode,
  output reg [6:0] convSixCode,
  output reg [5:0] railPowerGood
);
  // ----------------------------------------
  // variant dependent reset values
  // ----------------------------------------
  // fixed per build; the host cannot change which variant it talks to
  localparam [6:0] CONV6_RST = (VARIANT == 2'h1) ? `RCRB_RST_CONV6_B :
                               (VARIANT == 2'h2) ? `RCRB_RST_CONV6_C : `RCRB_RST_CONV6_A;
  localparam [3:0] LIN2_RST = (VARIANT == 2'h3) ? `RCRB_RST_LIN_Z : `RCRB_RST_LIN_A;
  localparam [3:0] LIN3_RST = (VARIANT == 2'h3) ? `RCRB_RST_LIN_Z : `RCRB_RST_LIN3_A;
  localparam [2:0] MODE_RST = (VARIANT == 2'h2) ? 3'h4 : 3'h0;
  localparam integer TICK_DIV = `RCRB_CLK_MHZ * `RCRB_TICK_US;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [2:0] powerOkDelayCode;
  reg forceShutdownBit;
  reg [6:0] convFourVoltageCode;
  reg [6:0] convFiveVoltageCode;
  reg [6:0] convSixVoltageCode;
  reg [3:0] linregTwoSleepCode;
  reg [3:0] linregTwoVoltageCode;
  reg [3:0] linregThreeSleepCode;
  reg [3:0] linregThreeVoltageCode;
  reg [2:0] convPwm;
  reg [2:0] convForceOffN;
  reg [7:0] railEnableOverride;
  wire tick;
  wire powerOkRaw;
  reg [7:0] next_rdata;
  wire [5:0] railZero;
  wire [6:0] zeroSel [0:5];
  wire anyRailZero;
  wire [5:0] next_convOn;
  wire [5:0] next_railPowerGood;
  wire next_linregTwoOn;
  wire next_switchAOn;
  wire [3:0] next_linregTwoCode;
  wire [3:0] next_linregThreeCode;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // reserved and read-only bits are never stored
  wire hitDelay = regWrite && (regAddr == `RCRB_OFS_POWER_OK_DELAY);
  wire hitShutdown = regWrite && (regAddr == `RCRB_OFS_FORCE_SHDN);
  wire hitConvFour = regWrite && (regAddr == `RCRB_OFS_CONV4);
  wire hitConvFive = regWrite && (regAddr == `RCRB_OFS_CONV5);
  wire hitConvSix = regWrite && (regAddr == `RCRB_OFS_CONV6);
  wire hitLinTwo = regWrite && (regAddr == `RCRB_OFS_LIN2);
  wire hitLinThree = regWrite && (regAddr == `RCRB_OFS_LIN3);
  wire hitModeOff = regWrite && (regAddr == `RCRB_OFS_MODE_OFF);
  wire hitEnable = regWrite && (regAddr == `RCRB_OFS_ENABLE);

  always @(posedge clk) begin
    if (!nrst) begin
      powerOkDelayCode <= `RCRB_RST_DELAY_CODE;
      forceShutdownBit <= 1'b0;
      convFourVoltageCode <= `RCRB_RST_CONV4;
      convFiveVoltageCode <= `RCRB_RST_CONV5;
      convSixVoltageCode <= CONV6_RST;
      linregTwoSleepCode <= LIN2_RST;
      linregTwoVoltageCode <= LIN2_RST;
      linregThreeSleepCode <= LIN3_RST;
      linregThreeVoltageCode <= LIN3_RST;
      convPwm <= MODE_RST;
      convForceOffN <= 3'h7;
      railEnableOverride <= 8'h00;
    end else begin
      // self-clear after one cycle; new write wins over clear
      if (hitShutdown && regWdata[`RCRB_BIT_SHDN]) begin
        forceShutdownBit <= 1'b1;
      end else begin
        forceShutdownBit <= 1'b0;
      end
      if (hitDelay) begin
        powerOkDelayCode <= regWdata[2:0];
      end
      if (hitConvFour) begin
        convFourVoltageCode <= regWdata[6:0];
      end
      if (hitConvFive) begin
        convFiveVoltageCode <= regWdata[6:0];
      end
      if (hitConvSix) begin
        convSixVoltageCode <= regWdata[6:0];
      end
      if (hitLinTwo) begin
        linregTwoSleepCode <= regWdata[7:4];
        linregTwoVoltageCode <= regWdata[3:0];
      end
      if (hitLinThree) begin
        linregThreeSleepCode <= regWdata[7:4];
        linregThreeVoltageCode <= regWdata[3:0];
      end
      if (hitModeOff) begin
        convPwm <= regWdata[`RCRB_BIT_PWM_LO +: 3];
        convForceOffN <= regWdata[2:0];
      end
      if (hitEnable) begin
        railEnableOverride <= regWdata;
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    case (regAddr)
      `RCRB_OFS_POWER_OK_DELAY: next_rdata = {5'h00, powerOkDelayCode};
      // register reads zero at every read, even in the cycle the bit is set
      `RCRB_OFS_FORCE_SHDN: next_rdata = 8'h00;
      `RCRB_OFS_CONV4: next_rdata = {1'b0, convFourVoltageCode};
      `RCRB_OFS_CONV5: next_rdata = {1'b0, convFiveVoltageCode};
      `RCRB_OFS_CONV6: next_rdata = {1'b0, convSixVoltageCode};
      `RCRB_OFS_LIN2: next_rdata = {linregTwoSleepCode, linregTwoVoltageCode};
      `RCRB_OFS_LIN3: next_rdata = {linregThreeSleepCode, linregThreeVoltageCode};
      `RCRB_OFS_MODE_OFF: next_rdata = {2'h0, convPwm, convForceOffN};
      `RCRB_OFS_ENABLE: next_rdata = railEnableOverride;
      // unmapped offsets and reserved bits read as zero
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      // held between reads so the host may sample it late
      regRdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // power-ok delay
  // ----------------------------------------
  // one 1 us tick serves every delay code, so the timer needs no wide divider
  rcrb_tick_div #(
    .DIV(TICK_DIV)
  ) rcrb_tick_div_inst (
    .clk(clk),
    .nrst(nrst),
    .tick(tick)
  );

  // power-ok drops at once when any rail leaves regulation
  rcrb_pok_timer #(
    .US_SCALE(US_SCALE)
  ) rcrb_pok_timer_inst (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .allInReg(allRailsInRegulation),
    .delayCode(powerOkDelayCode),
    .powerOk(powerOkRaw)
  );

  // ----------------------------------------
  // power-good masking for 0 V codes
  // ----------------------------------------
  // converters one..three codes live elsewhere; only four..six are seen here
  assign zeroSel[0] = 7'h7F;
  assign zeroSel[1] = 7'h7F;
  assign zeroSel[2] = 7'h7F;
  assign zeroSel[3] = convFourVoltageCode;
  assign zeroSel[4] = convFiveVoltageCode;
  assign zeroSel[5] = convSixVoltageCode;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_rail
      assign railZero[gi] = (zeroSel[gi] == 7'h00);
      // any rail parked at 0 V holds every power-good high, not only its own
      assign next_railPowerGood[gi] = railPowerGoodRaw[gi] | anyRailZero |
                                      ~sleepStateN;
      if (gi < 3) begin : g_forced
        // force-off beats both the override and the sequencer
        assign next_convOn[gi] = convForceOffN[gi] &
                                 (railEnableOverride[gi] | seqConvEnable[gi]);
      end else begin : g_plain
        assign next_convOn[gi] = railEnableOverride[gi] | seqConvEnable[gi];
      end
    end
  endgenerate
  assign anyRailZero = |railZero;

  // ----------------------------------------
  // pin and override terms
  // ----------------------------------------
  assign next_linregTwoOn = railEnableOverride[`RCRB_BIT_LIN2_EN] | linearSwitchEnablePin;
  assign next_switchAOn = railEnableOverride[`RCRB_BIT_SWA_EN] |
                          linearSwitchEnablePin | switchAEnablePin;
  // sleep code is taken only while the sleep-state pin is low
  assign next_linregTwoCode = sleepStateN ? linregTwoVoltageCode : linregTwoSleepCode;
  assign next_linregThreeCode = sleepStateN ? linregThreeVoltageCode :
                                linregThreeSleepCode;

  // ----------------------------------------
  // rail enable outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      convOn <= 6'h00;
      convPwmSelect <= 3'h0;
      linregTwoOn <= 1'b0;
      switchAOn <= 1'b0;
    end else begin
      convOn <= next_convOn;
      convPwmSelect <= convPwm;
      linregTwoOn <= next_linregTwoOn;
      switchAOn <= next_switchAOn;
    end
  end

  // ----------------------------------------
  // voltage code outputs
  // ----------------------------------------
  // registered so a host write never glitches a regulator reference
  always @(posedge clk) begin
    if (!nrst) begin
      linregTwoCode <= 4'h0;
      linregThreeCode <= 4'h0;
      convFourCode <= 7'h00;
      convFiveCode <= 7'h00;
      convSixCode <= 7'h00;
    end else begin
      linregTwoCode <= next_linregTwoCode;
      linregThreeCode <= next_linregThreeCode;
      convFourCode <= convFourVoltageCode;
      convFiveCode <= convFiveVoltageCode;
      convSixCode <= convSixVoltageCode;
    end
  end

  // ----------------------------------------
  // status and shutdown outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      platformPowerOkOut <= 1'b0;
      emergencyShutdown <= 1'b0;
      railPowerGood <= 6'h00;
    end else begin
      platformPowerOkOut <= powerOkRaw;
      emergencyShutdown <= forceShutdownBit;
      railPowerGood <= next_railPowerGood;
    end
  end
endmodule

// ==== hdl/rcrb_defs.vh ====
`ifndef RCRB_DEFS_VH
`define RCRB_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RCRB_OFS_POWER_OK_DELAY 8'h43
`define RCRB_OFS_FORCE_SHDN 8'h91
`define RCRB_OFS_CONV4 8'h94
`define RCRB_OFS_CONV5 8'h96
`define RCRB_OFS_CONV6 8'h98
`define RCRB_OFS_LIN2 8'h9A
`define RCRB_OFS_LIN3 8'h9B
`define RCRB_OFS_MODE_OFF 8'h9C
`define RCRB_OFS_ENABLE 8'h9E
// ----------------------------------------
// reset values
// ----------------------------------------
`define RCRB_RST_DELAY_CODE 3'h7
`define RCRB_RST_CONV4 7'h2F
`define RCRB_RST_CONV5 7'h4B
`define RCRB_RST_CONV6_A 7'h3D
`define RCRB_RST_CONV6_B 7'h47
`define RCRB_RST_CONV6_C 7'h56
`define RCRB_RST_LIN_A 4'hA
`define RCRB_RST_LIN3_A 4'hB
`define RCRB_RST_LIN_Z 4'h0
// ----------------------------------------
// field positions
// ----------------------------------------
`define RCRB_BIT_SHDN 0
`define RCRB_BIT_PWM_LO 3
`define RCRB_BIT_LIN2_EN 7
`define RCRB_BIT_SWA_EN 6
// ----------------------------------------
// delay table in microseconds
// ----------------------------------------
`define RCRB_DLY0_US 2500
`define RCRB_DLY1_US 5000
`define RCRB_DLY2_US 10000
`define RCRB_DLY3_US 15000
`define RCRB_DLY4_US 20000
`define RCRB_DLY5_US 50000
`define RCRB_DLY6_US 75000
`define RCRB_DLY7_US 100000
`define RCRB_CLK_MHZ 40
`define RCRB_TICK_US 1
`endif

// ==== hdl/rcrb_tick_div.v ====
module rcrb_tick_div #(
  parameter integer DIV = 40
) (
  input wire clk,
  input wire nrst,
  output reg tick
);
  reg [15:0] cnt;

  always @(posedge clk) begin
    if (!nrst) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == DIV[15:0] - 16'h0001) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== hdl/rcrb_pok_timer.v ====
`include "rcrb_defs.vh"
module rcrb_pok_timer #(
  parameter integer US_SCALE = 1
) (
  input wire clk,
  input wire nrst,
  input wire tick,
  input wire allInReg,
  input wire [2:0] delayCode,
  output reg powerOk
);
  reg [16:0] count;
  reg [31:0] limitFull;
  wire [16:0] limit;

  // delay entries; US_SCALE lets a bench shorten them
  always @* begin
    case (delayCode)
      3'h0: limitFull = `RCRB_DLY0_US / US_SCALE;
      3'h1: limitFull = `RCRB_DLY1_US / US_SCALE;
      3'h2: limitFull = `RCRB_DLY2_US / US_SCALE;
      3'h3: limitFull = `RCRB_DLY3_US / US_SCALE;
      3'h4: limitFull = `RCRB_DLY4_US / US_SCALE;
      3'h5: limitFull = `RCRB_DLY5_US / US_SCALE;
      3'h6: limitFull = `RCRB_DLY6_US / US_SCALE;
      default: limitFull = `RCRB_DLY7_US / US_SCALE;
    endcase
  end
  // longest entry stays below 2^17, so the cut drops only zeros
  assign limit = limitFull[16:0];

  always @(posedge clk) begin
    if (!nrst || !allInReg) begin
      count <= 17'h00000;
      powerOk <= 1'b0;
    end else if (count >= limit) begin
      powerOk <= 1'b1;
    end else if (tick) begin
      count <= count + 17'h00001;
    end
  end
endmodule

// ==== testbench/rcrb_host_model.sv ====
module rcrb_host_model (
  input logic clk,
  input logic [7:0] regRdata,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // idle address and data are inverted so a stale value is never mistaken for a live one
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clk);
    #1 d = regRdata;
  endtask
endmodule

// ==== testbench/rcrb_rail_control_bank_props.sv ====
module rcrb_rail_control_bank_props (
  input logic clk,
  input logic nrst,
  input logic regWrite,
  input logic regRead,
  input logic [7:0] regAddr,
  input logic [7:0] regWdata,
  input logic [7:0] regRdata,
  input logic sleepStateN,
  input logic linearSwitchEnablePin,
  input logic switchAEnablePin,
  input logic allRailsInRegulation,
  input logic platformPowerOkOut,
  input logic emergencyShutdown,
  input logic [5:0] convOn,
  input logic linregTwoOn,
  input logic switchAOn,
  input logic [6:0] convFourCode,
  input logic [5:0] railPowerGood
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence sdWrite;
    regWrite && regAddr == 8'h91 && regWdata[0];
  endsequence
  sequence sdPulse;
    !emergencyShutdown ##1 emergencyShutdown ##1 !emergencyShutdown;
  endsequence
  a_shdn_pulse: assert property (sdWrite |=> sdPulse)
    else $error("shutdown pulse missing after write of one");
  a_shdn_cause: assert property (emergencyShutdown |->
    $past(regWrite, 2) && $past(regAddr, 2) == 8'h91 && $past(regWdata[0], 2))
    else $error("shutdown pulse without a write of one");
  a_shdn_reads_zero: assert property (regRead && regAddr == 8'h91 |=> regRdata == 8'h00)
    else $error("shutdown register read not zero");
  a_force_off_wins: assert property (regWrite && regAddr == 8'h9C && !regWdata[0]
    |-> ##2 !convOn[0])
    else $error("converter one on despite force-off");
  a_override_forces_on: assert property (regWrite && regAddr == 8'h9E && regWdata[5]
    |-> ##2 convOn[5])
    else $error("converter six override ignored");
  a_zero_code_good: assert property (convFourCode == 7'h00 [*4] |-> railPowerGood == 6'h3F)
    else $error("power good low with zero code");
  a_lin_two_pin: assert property (linearSwitchEnablePin [*4] |-> linregTwoOn)
    else $error("linear regulator two off with pin high");
  a_switch_pin: assert property ((linearSwitchEnablePin || switchAEnablePin) [*4]
    |-> switchAOn)
    else $error("switch A off with a pin high");
  a_pok_drops: assert property (!allRailsInRegulation [*4] |-> !platformPowerOkOut)
    else $error("power ok high without regulation");
endmodule
bind rcrb_rail_control_bank rcrb_rail_control_bank_props rcrb_rail_control_bank_props_inst (
  .clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .sleepStateN,
  .linearSwitchEnablePin, .switchAEnablePin, .allRailsInRegulation, .platformPowerOkOut,
  .emergencyShutdown, .convOn, .linregTwoOn, .switchAOn, .convFourCode, .railPowerGood);

// ==== testbench/rcrb_rail_control_bank_tb.sv ====
module rcrb_rail_control_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, regWrite, regRead, sleepStateN, linearSwitchEnablePin, switchAEnablePin;
  logic allRailsInRegulation, platformPowerOkOut, emergencyShutdown, linregTwoOn, switchAOn;
  logic [7:0] regAddr, regWdata, regRdata;
  logic [5:0] seqConvEnable, railPowerGoodRaw, convOn, railPowerGood;
  logic [2:0] convPwmSelect;
  logic [3:0] linregTwoCode, linregThreeCode;
  logic [6:0] convFourCode, convFiveCode, convSixCode;
  integer failures = 0;
  integer total_checks = 0;
  localparam logic [7:0] OFS [0:9] = '{8'h43, 8'h91, 8'h94, 8'h96, 8'h98, 8'h9A, 8'h9B,
    8'h9C, 8'h9E, 8'h50};
  localparam logic [7:0] RST [0:9] = '{8'h07, 8'h00, 8'h2F, 8'h4B, 8'h3D, 8'hAA, 8'hBB,
    8'h07, 8'h00, 8'h00};
  // scaled delays keep power-ok counts in the hundreds of cycles
  rcrb_rail_control_bank #(.VARIANT(2'h0), .US_SCALE(1000)) rcrb_rail_control_bank_inst (
    .clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .sleepStateN,
    .linearSwitchEnablePin, .switchAEnablePin, .seqConvEnable, .allRailsInRegulation,
    .railPowerGoodRaw, .platformPowerOkOut, .emergencyShutdown, .convOn, .convPwmSelect,
    .linregTwoOn, .switchAOn, .linregTwoCode, .linregThreeCode, .convFourCode,
    .convFiveCode, .convSixCode, .railPowerGood);
  rcrb_host_model rcrb_host_model_inst (.clk, .regRdata, .regWrite, .regRead, .regAddr,
    .regWdata);
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task rw(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] r;
    rcrb_host_model_inst.wr(a, d);
    rcrb_host_model_inst.rd(a, r);
    chk("readback", r, e);
  endtask
  task settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task t_reset();
    logic [7:0] r;
    for (int i = 0; i < 10; i++) begin
      rcrb_host_model_inst.rd(OFS[i], r);
      chk("reset value", r, RST[i]);
    end
    chk("conv six code", convSixCode, 8'h3D);
    $display("test reset done");
  endtask
  task t_fields();
    rw(8'h94, 8'h55, 8'h55);
    chk("conv four code", convFourCode, 8'h55);
    rw(8'h96, 8'h12, 8'h12);
    chk("conv five code", convFiveCode, 8'h12);
    rw(8'h91, 8'hFE, 8'h00);
    rw(8'h94, 8'h00, 8'h00);
    chk("power good", railPowerGood, 8'h3F);
    $display("test fields done");
  endtask
  task t_shutdown();
    integer n, pos;
    n = 0;
    pos = 0;
    rcrb_host_model_inst.wr(8'h91, 8'h00);
    for (int i = 1; i < 6; i++) begin
      @(posedge clk);
      #1;
      if (emergencyShutdown === 1'b1) n++;
    end
    chk("pulses after zero", n, 0);
    rcrb_host_model_inst.wr(8'h91, 8'h01);
    for (int i = 1; i < 6; i++) begin
      @(posedge clk);
      #1;
      if (emergencyShutdown === 1'b1) begin
        n++;
        pos = i;
      end
    end
    chk("pulse count", n, 1);
    chk("pulse cycle", pos, 1);
    rw(8'h91, 8'h00, 8'h00);
    $display("test shutdown done");
  endtask
  task t_sleep();
    rw(8'h9A, 8'h3C, 8'h3C);
    rw(8'h9B, 8'h5A, 8'h5A);
    chk("lin two normal", linregTwoCode, 8'h0C);
    chk("lin three normal", linregThreeCode, 8'h0A);
    @(posedge clk) sleepStateN <= 1'b0;
    settle();
    chk("lin two sleep", linregTwoCode, 8'h03);
    chk("lin three sleep", linregThreeCode, 8'h05);
    rw(8'h9A, 8'hCC, 8'hCC);
    chk("lin two equal", linregTwoCode, 8'h0C);
    @(posedge clk) sleepStateN <= 1'b1;
    settle();
    chk("lin two awake", linregTwoCode, 8'h0C);
    $display("test sleep done");
  endtask
  task t_enable();
    rw(8'h9C, 8'hFE, 8'h3E);
    chk("pwm select", convPwmSelect, 8'h07);
    rw(8'h9E, 8'h3F, 8'h3F);
    chk("conv on override", convOn, 8'h3E);
    chk("lin two off", linregTwoOn, 8'h00);
    @(posedge clk) switchAEnablePin <= 1'b1;
    settle();
    chk("switch a pin", switchAOn, 8'h01);
    @(posedge clk) switchAEnablePin <= 1'b0;
    rw(8'h9E, 8'hC0, 8'hC0);
    chk("lin two forced", linregTwoOn, 8'h01);
    chk("switch a forced", switchAOn, 8'h01);
    rw(8'h9C, 8'h07, 8'h07);
    rw(8'h9E, 8'h00, 8'h00);
    @(posedge clk) seqConvEnable <= 6'h3F;
    linearSwitchEnablePin <= 1'b1;
    settle();
    chk("conv on sequenced", convOn, 8'h3F);
    chk("lin two pin", linregTwoOn, 8'h01);
    $display("test enable done");
  endtask
  task t_pok();
    integer n;
    n = 0;
    rw(8'h43, 8'hF9, 8'h01);
    @(posedge clk) allRailsInRegulation <= 1'b1;
    while (platformPowerOkOut !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      failures++;
      results();
    end
    // one 1 us tick is 40 cycles, so the first tick may land early
    chk("power_ok_delay", (n >= 155 && n <= 210), 8'h01);
    @(posedge clk) allRailsInRegulation <= 1'b0;
    settle();
    chk("pok drop", platformPowerOkOut, 8'h00);
    $display("test power ok done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    sleepStateN = 1'b1;
    linearSwitchEnablePin = 1'b0;
    switchAEnablePin = 1'b0;
    seqConvEnable = 6'h00;
    allRailsInRegulation = 1'b0;
    railPowerGoodRaw = 6'h00;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_fields();
    t_shutdown();
    t_sleep();
    t_enable();
    t_pok();
    results();
  end
endmodule
